// ==== src/dsp_memory_subsystem.sv ====
// Data, program and boot memories of one DSP core with mode bit
module dsp_memory_subsystem #(
  // One instance per core, so no memory is ever shared between cores;
  // the second core uses the larger program depth
  parameter int PROG_RAM_WORDS = dms_pkg::PROG_RAM0_WORDS  // RULE1
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  // Core reset bit from the clock control register
  input  wire logic        dsp_reset_bit_i,
  // X data space
  input  wire logic [15:0] x_address_bus_i,
  input  wire logic        x_rd_i,
  input  wire logic        x_wr_i,
  input  wire logic [23:0] x_wdata_i,
  input  wire logic [23:0] x_periph_rdata_i,
  output logic      [23:0] x_data_bus_o,
  output logic             x_valid_o,
  output logic             x_periph_sel_o,
  // Y data space
  input  wire logic [15:0] y_address_bus_i,
  input  wire logic        y_rd_i,
  input  wire logic        y_wr_i,
  input  wire logic [23:0] y_wdata_i,
  input  wire logic [23:0] y_periph_rdata_i,
  output logic      [23:0] y_data_bus_o,
  output logic             y_valid_o,
  output logic             y_periph_sel_o,
  // Instruction fetch
  input  wire logic [15:0] program_address_bus_i,
  input  wire logic        fetch_i,
  output logic      [23:0] program_data_bus_o,
  output logic             fetch_valid_o,
  // Program memory move
  input  wire logic [15:0] pmove_address_i,
  input  wire logic        pmove_rd_i,
  input  wire logic        pmove_wr_i,
  input  wire logic [23:0] pmove_wdata_i,
  output logic      [23:0] pmove_rdata_o,
  output logic             pmove_valid_o,
  // Operating mode register
  input  wire logic        mode_wr_i,
  input  wire logic        mode_wdata_i,
  output logic             boot_mode_o
);
  // Whole registered state of the block
  typedef struct packed {
    logic [23:0] xd;    // X read word
    logic        xv;    // X read valid
    logic        xps;   // X access went to peripheral space
    logic [23:0] yd;    // Y read word
    logic        yv;    // Y read valid
    logic        yps;   // Y access went to peripheral space
    logic [23:0] pd;    // Fetched instruction word
    logic        pv;    // Fetch valid
    logic [23:0] md;    // Move read word
    logic        mv;    // Move read valid
    logic        boot;  // Operating mode bit
  } dms_state_s;

  dms_state_s st;       // Current state
  dms_state_s next_st;  // Next state

  dms_pkg::dms_src_e xsrc;   // X bus decode
  dms_pkg::dms_src_e ysrc;   // Y bus decode
  logic              mbusy;  // Move owns the program RAM port
  logic              fok;    // Fetch served this cycle

  // Memory ports
  dms_mem_if x_ram_p ();  // X data RAM
  dms_mem_if x_rom_p ();  // X data ROM
  dms_mem_if y_ram_p ();  // Y data RAM
  dms_mem_if y_rom_p ();  // Y data ROM
  dms_mem_if p_ram_p ();  // Program RAM, shared by fetch and move
  dms_mem_if brom_p ();   // Bootstrap ROM, fetch only

  // Bus source picked from the decoded region
  function automatic logic [23:0] lane(input dms_pkg::dms_src_e s,
                                       input logic [23:0] ram,
                                       input logic [23:0] rom,
                                       input logic [23:0] per);
    case (s)
      dms_pkg::DMS_SRC_RAM:    lane = ram;
      dms_pkg::DMS_SRC_ROM:    lane = rom;
      dms_pkg::DMS_SRC_PERIPH: lane = per;
      default:                 lane = 24'h000000;
    endcase
  endfunction

  // Separate memory set per core instance
  // X data RAM, single port
  dms_spram #(.WORDS(dms_pkg::XDATA_RAM_WORDS)) u_x_ram (  // RULE2
    .mclk_i (mclk_i),
    .port   (x_ram_p)
  );
  // Y data RAM, single port
  dms_spram #(.WORDS(dms_pkg::YDATA_RAM_WORDS)) u_y_ram (  // RULE4
    .mclk_i (mclk_i),
    .port   (y_ram_p)
  );
  // Program RAM; depth set per core
  dms_spram #(.WORDS(PROG_RAM_WORDS)) u_p_ram (  // RULE5 RULE1
    .mclk_i (mclk_i),
    .port   (p_ram_p)
  );
  // Factory data ROMs on the X and Y buses
  dms_rom #(.WORDS(dms_pkg::DROM_WORDS), .KIND(dms_pkg::KIND_X_ROM)) u_x_rom (
    .port (x_rom_p)
  );
  dms_rom #(.WORDS(dms_pkg::DROM_WORDS), .KIND(dms_pkg::KIND_Y_ROM)) u_y_rom (
    .port (y_rom_p)
  );
  // Bootstrap ROM with the loader routine
  dms_rom #(.WORDS(dms_pkg::BROM_WORDS), .KIND(dms_pkg::KIND_BROM)) u_brom (
    .port (brom_p)  // RULE11
  );

  // Port drive; ROM ports never write
  always_comb begin
    xsrc = dms_pkg::decode(x_address_bus_i);  // RULE16
    ysrc = dms_pkg::decode(y_address_bus_i);  // RULE16
    // X space: RAM written only when its range is decoded
    x_ram_p.addr  = x_address_bus_i;  // RULE2
    x_ram_p.we    = x_wr_i && (xsrc == dms_pkg::DMS_SRC_RAM);  // RULE3
    x_ram_p.wdata = x_wdata_i;
    x_rom_p.addr  = x_address_bus_i - dms_pkg::ROM_BASE;
    x_rom_p.we    = 1'b0;
    x_rom_p.wdata = 24'h000000;
    // Y space mirrors the X space
    y_ram_p.addr  = y_address_bus_i;
    y_ram_p.we    = y_wr_i && (ysrc == dms_pkg::DMS_SRC_RAM);  // RULE4
    y_ram_p.wdata = y_wdata_i;
    y_rom_p.addr  = y_address_bus_i - dms_pkg::ROM_BASE;
    y_rom_p.we    = 1'b0;
    y_rom_p.wdata = 24'h000000;
    // Move takes the single program port over fetch
    mbusy         = pmove_rd_i || pmove_wr_i;
    p_ram_p.addr  = mbusy ? pmove_address_i : program_address_bus_i; // RULE6
    // Only the move instruction can store code; boot loads use it too
    p_ram_p.we    = pmove_wr_i;  // RULE7 RULE12
    p_ram_p.wdata = pmove_wdata_i;
    brom_p.addr  = program_address_bus_i;  // RULE17
    brom_p.we    = 1'b0;
    brom_p.wdata = 24'h000000;
    // Boot fetch uses the boot ROM, so a load never stalls it
    fok = fetch_i && (st.boot || !mbusy);
  end

  // Next state
  always_comb begin
    next_st = st;
    // Word is driven only for a read; ROM only when its range is hit
    next_st.xd  = x_rd_i ? lane(xsrc, x_ram_p.rdata, x_rom_p.rdata,
                                x_periph_rdata_i) : 24'h000000;  // RULE9
    next_st.xv  = x_rd_i;  // RULE3
    next_st.xps = (x_rd_i || x_wr_i) &&
                  (xsrc == dms_pkg::DMS_SRC_PERIPH);  // RULE3
    next_st.yd  = y_rd_i ? lane(ysrc, y_ram_p.rdata, y_rom_p.rdata,
                                y_periph_rdata_i) : 24'h000000;  // RULE10
    next_st.yv  = y_rd_i;  // RULE4
    next_st.yps = (y_rd_i || y_wr_i) &&
                  (ysrc == dms_pkg::DMS_SRC_PERIPH);  // RULE4
    // Instruction word toward the decode controller
    if (!fok) begin
      next_st.pd = 24'h000000;
    end else if (st.boot) begin
      next_st.pd = brom_p.rdata;  // RULE17
    end else begin
      next_st.pd = p_ram_p.rdata;  // RULE8
    end
    next_st.pv = fok;  // RULE8
    // Move read returns the old word if written in the same cycle
    next_st.md = pmove_rd_i ? p_ram_p.rdata : 24'h000000;  // RULE6
    next_st.mv = pmove_rd_i;
    // Core reset sets boot mode and wins over a clear
    if (dsp_reset_bit_i) begin
      next_st.boot = 1'b1;  // RULE14
    end else if (mode_wr_i) begin
      next_st.boot = mode_wdata_i;  // RULE13 RULE15
    end
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st      <= '0;
      st.boot <= dms_pkg::BOOT_MODE_RST;  // RULE13
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign x_data_bus_o       = st.xd;
  assign x_valid_o          = st.xv;
  assign x_periph_sel_o     = st.xps;
  assign y_data_bus_o       = st.yd;
  assign y_valid_o          = st.yv;
  assign y_periph_sel_o     = st.yps;
  assign program_data_bus_o = st.pd;
  assign fetch_valid_o      = st.pv;
  assign pmove_rdata_o      = st.md;
  assign pmove_valid_o      = st.mv;
  assign boot_mode_o        = st.boot;

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  // ROM words appear only for reads inside the ROM range
  a_x_rom_route: assert property (  // RULE9
    x_rd_i && x_address_bus_i >= dms_pkg::ROM_BASE &&
    x_address_bus_i <= dms_pkg::ROM_END |=> x_valid_o &&
    x_data_bus_o == dms_pkg::rom_word(dms_pkg::KIND_X_ROM,
                                      $past(x_address_bus_i)))
    else $error("X ROM word not on X data bus");
  a_y_rom_route: assert property (  // RULE10
    y_rd_i && y_address_bus_i >= dms_pkg::ROM_BASE &&
    y_address_bus_i <= dms_pkg::ROM_END |=>
    y_data_bus_o == dms_pkg::rom_word(dms_pkg::KIND_Y_ROM,
                                      $past(y_address_bus_i)))
    else $error("Y ROM word not on Y data bus");
  a_x_idle_zero: assert property (  // RULE9
    !x_rd_i |=> x_data_bus_o == 24'h000000 && !x_valid_o)
    else $error("X data bus driven without a read");
  // Idle Y bus shows zero, so a stale word is never decoded
  a_y_idle_zero: assert property (  // RULE10
    !y_rd_i |=> y_data_bus_o == 24'h000000 && !y_valid_o)
    else $error("Y data bus driven without a read");
  // A word written to RAM is read back in the next cycle
  a_x_ram_wr_rd: assert property (  // RULE2
    x_wr_i && x_address_bus_i <= dms_pkg::RAM_END ##1
    x_rd_i && !x_wr_i && x_address_bus_i == $past(x_address_bus_i)
    |=> x_data_bus_o == $past(x_wdata_i, 2))
    else $error("X RAM read does not return written word");
  a_y_ram_wr_rd: assert property (  // RULE4
    y_wr_i && y_address_bus_i <= dms_pkg::RAM_END ##1
    y_rd_i && !y_wr_i && y_address_bus_i == $past(y_address_bus_i)
    |=> y_data_bus_o == $past(y_wdata_i, 2))
    else $error("Y RAM read does not return written word");
  a_xper_route: assert property (  // RULE16
    x_rd_i && x_address_bus_i >= dms_pkg::PERIPH_BASE |=>
    x_periph_sel_o && x_data_bus_o == $past(x_periph_rdata_i))
    else $error("Peripheral read not routed to X bus");
  // Select only for peripheral space, never for RAM or ROM
  a_xper_excl: assert property (  // RULE16
    x_address_bus_i < dms_pkg::PERIPH_BASE |=> !x_periph_sel_o)
    else $error("Peripheral select outside peripheral space");
  // Code stored by a move is what a later fetch returns
  a_prog_load: assert property (  // RULE7
    pmove_wr_i && !pmove_rd_i &&
    pmove_address_i < 16'(PROG_RAM_WORDS) && !boot_mode_o ##1
    fetch_i && !mbusy && !boot_mode_o && !dsp_reset_bit_i &&
    program_address_bus_i == $past(pmove_address_i)
    |=> fetch_valid_o && program_data_bus_o == $past(pmove_wdata_i, 2))
    else $error("Fetch does not see word stored by move");
  a_boot_fetch: assert property (  // RULE17
    fetch_i && boot_mode_o &&
    program_address_bus_i < 16'(dms_pkg::BROM_WORDS) |=>
    fetch_valid_o && program_data_bus_o == dms_pkg::rom_word(
      dms_pkg::KIND_BROM, $past(program_address_bus_i)))
    else $error("Boot mode fetch not from boot ROM");
  a_fetch_stall: assert property (  // RULE6
    fetch_i && !boot_mode_o && mbusy |=> !fetch_valid_o)
    else $error("Fetch served while move owns program RAM");
  // A fetch with a free program port is always answered
  a_fetch_served: assert property (  // RULE8
    fetch_i && !mbusy |=> fetch_valid_o)
    else $error("Fetch with free port not answered");
  // No fetch, no word toward the decode controller
  a_fetch_idle: assert property (  // RULE8
    !fetch_i |=> !fetch_valid_o && program_data_bus_o == 24'h000000)
    else $error("Instruction word without a fetch");
  // Every move read is answered in the next cycle
  a_move_read: assert property (  // RULE6
    pmove_rd_i |=> pmove_valid_o)
    else $error("Move read not answered");
  a_boot_set: assert property (  // RULE14
    dsp_reset_bit_i |=> boot_mode_o [*1])
    else $error("Core reset did not set boot mode");
  a_boot_hold: assert property (  // RULE13
    !dsp_reset_bit_i && !mode_wr_i |=> $stable(boot_mode_o))
    else $error("Mode bit changed without a write");
  // A mode write without core reset loads the written value
  a_mode_load: assert property (  // RULE15
    mode_wr_i && !dsp_reset_bit_i |=> boot_mode_o == $past(mode_wdata_i))
    else $error("Mode write not taken");

  // Main scenarios

  c_boot_exit: cover property (boot_mode_o ##1 !boot_mode_o);
  c_pmove_load: cover property (pmove_wr_i && boot_mode_o);
  c_normal_fetch: cover property (fetch_i && !mbusy && !boot_mode_o);
  c_rom_read: cover property (x_rd_i && xsrc == dms_pkg::DMS_SRC_ROM);
  c_per_read: cover property (y_rd_i && ysrc == dms_pkg::DMS_SRC_PERIPH);
endmodule // dsp_memory_subsystem

// ==== include/dms_pkg.sv ====
// Constants, decode and ROM contents shared by the DSP memory subsystem
// Functional notes
// RULE1: Each core has its own memory set
// RULE2: X RAM 512x24, 16-bit address bus
// RULE3: X data bus reads/writes RAM, reaches peripherals
// RULE4: Y RAM 512x24 over Y data bus
// RULE5: Program RAM 1024 or 5632 words
// RULE6: Program address from fetch or move unit
// RULE7: Program RAM written only by move instruction
// RULE8: Fetched word goes to decode controller
// RULE9: X ROM drives bus only when addressed
// RULE10: Y ROM drives bus only when addressed
// RULE11: 128-word boot ROM holds init routine
// RULE12: Boot code loads program, X, Y memory
// RULE13: One mode bit selects boot or normal
// RULE14: DSP reset bit sets boot mode
// RULE15: Boot code clears bit to run normally
// RULE16: Non-overlapping RAM, ROM, peripheral decode ranges
// RULE17: Boot mode fetches from boot ROM
package dms_pkg;
  localparam int DATA_W          = 24;    // Word width of every memory
  localparam int ADDR_W          = 16;    // Address bus width
  localparam int XDATA_RAM_WORDS = 512;   // X data RAM depth
  localparam int YDATA_RAM_WORDS = 512;   // Y data RAM depth
  localparam int PROG_RAM0_WORDS = 1024;  // Program RAM depth, first core
  localparam int PROG_RAM1_WORDS = 5632;  // Program RAM depth, second core
  localparam int DROM_WORDS      = 256;   // X and Y data ROM depth
  localparam int BROM_WORDS      = 128;   // Bootstrap ROM depth
  // Data space map
  localparam logic [15:0] RAM_BASE    = 16'h0000;
  localparam logic [15:0] ROM_BASE    = 16'h0200;
  localparam logic [15:0] ROM_END     = 16'h02ff;
  localparam logic [15:0] RAM_END     = 16'h01ff;
  localparam logic [15:0] PERIPH_BASE = 16'hffc0;
  // Reset value of the operating mode bit: boot
  localparam logic        BOOT_MODE_RST = 1'b1;
  // ROM content tags (arbitrary pattern, stands in for factory contents)
  localparam logic [7:0]  KIND_X_ROM = 8'h0a;
  localparam logic [7:0]  KIND_Y_ROM = 8'h0b;
  localparam logic [7:0]  KIND_BROM = 8'h0c;

  // Source selected on a data bus, Gray coded
  typedef enum logic [1:0] {
    DMS_SRC_NONE   = 2'b00,
    DMS_SRC_RAM    = 2'b01,
    DMS_SRC_ROM    = 2'b11,
    DMS_SRC_PERIPH = 2'b10
  } dms_src_e;

  // Data space decode, shared by the X and Y buses
  function automatic dms_src_e decode(input logic [15:0] a);
    if (a <= RAM_END) begin
      decode = DMS_SRC_RAM;
    end else if (a >= ROM_BASE && a <= ROM_END) begin
      decode = DMS_SRC_ROM;
    end else if (a >= PERIPH_BASE) begin
      decode = DMS_SRC_PERIPH;
    end else begin
      decode = DMS_SRC_NONE;
    end
  endfunction

  // Factory ROM word at a given index
  function automatic logic [23:0] rom_word(input logic [7:0] kind,
                                           input logic [15:0] idx);
    rom_word = {kind, 8'h00, idx[7:0]};
  endfunction
endpackage : dms_pkg

// ==== include/dms_mem_if.sv ====
// Port bundle between the subsystem and one memory array
interface dms_mem_if;
  logic [15:0] addr;   // Word index inside the array
  logic        we;     // Write strobe
  logic [23:0] wdata;  // Write word
  logic [23:0] rdata;  // Read word, combinational
  modport user (output addr, output we, output wdata, input rdata);
  modport mem  (input addr, input we, input wdata, output rdata);
endinterface : dms_mem_if

// ==== src/dms_spram.sv ====
// Single-port RAM, written on the clock, read asynchronously
module dms_spram #(
  parameter int WORDS = 512
) (
  // Clock
  input  wire logic mclk_i,
  // Memory port
  dms_mem_if.mem    port
);
  localparam int IW = $clog2(WORDS);
  // Storage array
  logic [23:0] mem [WORDS];
  logic        in_range;

  // Out-of-range index never touches storage
  always_comb begin
    in_range = port.addr < 16'(WORDS);
  end

  // Write on the clock edge
  always_ff @(posedge mclk_i) begin
    if (port.we && in_range) begin
      mem[port.addr[IW-1:0]] <= port.wdata;
    end
  end

  // Read returns zero outside the array
  assign port.rdata = in_range ? mem[port.addr[IW-1:0]] : 24'h000000;
endmodule // dms_spram

// ==== src/dms_rom.sv ====
// Factory ROM with a fixed content pattern
module dms_rom #(
  parameter int         WORDS = 256,
  parameter logic [7:0] KIND  = 8'h0a
) (
  // Memory port, writes ignored
  dms_mem_if.mem port
);
  // Index beyond the ROM reads zero
  assign port.rdata = (port.addr < 16'(WORDS)) ?
                      dms_pkg::rom_word(KIND, port.addr) : 24'h000000;
endmodule // dms_rom

// ==== verif/dms_core_model.sv ====
// Behavioural DSP core that issues requests to one memory subsystem
module dms_core_model (
  // Clock
  input  wire logic        mclk_i,
  // X data requests
  output logic      [15:0] xa_o,
  output logic             xr_o,
  output logic             xw_o,
  output logic      [23:0] xd_o,
  output logic      [23:0] xp_o,
  // Y data requests
  output logic      [15:0] ya_o,
  output logic             yr_o,
  output logic             yw_o,
  output logic      [23:0] yd_o,
  output logic      [23:0] yp_o,
  // Fetch, move and mode requests
  output logic      [15:0] pa_o,
  output logic             pf_o,
  output logic      [15:0] ma_o,
  output logic             mr_o,
  output logic             mw_o,
  output logic      [23:0] md_o,
  output logic             mw_mode_o,
  output logic             md_mode_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle state at time zero
  initial begin
    {xa_o, xr_o, xw_o, xd_o, ya_o, yr_o, yw_o, yd_o} = '0;
    {pa_o, pf_o, ma_o, mr_o, mw_o, md_o, mw_mode_o, md_mode_o} = '0;
    xp_o = 24'h5a3c96;
    yp_o = 24'h1e2d4b;
  end

  // Peripheral words change every cycle, so a stale word never matches
  always @(posedge mclk_i) begin
    xp_o <= {xp_o[22:0], ~xp_o[23]};
    yp_o <= {yp_o[22:0], ~yp_o[23]};
  end

  // Data request on X (y=0) or Y (y=1), held until the next tick
  task automatic dreq(input bit y, input logic r, input logic w,
                      input logic [15:0] a, input logic [23:0] d);
    if (y) begin
      {yr_o, yw_o, ya_o, yd_o} = {r, w, a, d};
    end else begin
      {xr_o, xw_o, xa_o, xd_o} = {r, w, a, d};
    end
  endtask

  // Instruction fetch request
  task automatic fetch(input logic f, input logic [15:0] a);
    {pf_o, pa_o} = {f, a};
  endtask

  // Program memory move request
  task automatic move(input logic r, input logic w,
                      input logic [15:0] a, input logic [23:0] d);
    {mr_o, mw_o, ma_o, md_o} = {r, w, a, d};
  endtask

  // Mode write; boot code clears the bit before running from RAM
  task automatic mode(input logic w, input logic v);
    {mw_mode_o, md_mode_o} = {w, v};
  endtask

  // Drop every strobe
  task automatic clear();
    {xr_o, xw_o, yr_o, yw_o, pf_o, mr_o, mw_o, mw_mode_o} = '0;
  endtask

  // Hold requests over one rising edge, then step just past it
  task automatic tick();
    @(posedge mclk_i);
    #1;
  endtask
endmodule  // dms_core_model

// ==== verif/tb_top.sv ====
// Self-checking bench for one core's memory subsystem
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PW = dms_pkg::PROG_RAM0_WORDS;  // First core depth
  localparam logic [7:0] KB = dms_pkg::KIND_BROM;

  logic        mclk_i, sys_rst_i, dsp_reset_bit_i;
  logic [15:0] x_address_bus_i, y_address_bus_i;
  logic [15:0] program_address_bus_i, pmove_address_i;
  logic        x_rd_i, x_wr_i, y_rd_i, y_wr_i, fetch_i;
  logic        pmove_rd_i, pmove_wr_i, mode_wr_i, mode_wdata_i;
  logic [23:0] x_wdata_i, x_periph_rdata_i, y_wdata_i, y_periph_rdata_i;
  logic [23:0] pmove_wdata_i, x_data_bus_o, y_data_bus_o;
  logic [23:0] program_data_bus_o, pmove_rdata_o;
  logic        x_valid_o, x_periph_sel_o, y_valid_o, y_periph_sel_o;
  logic        fetch_valid_o, pmove_valid_o, boot_mode_o;
  int          mismatches = 0;
  int          total_checks = 0;

  dsp_memory_subsystem #(.PROG_RAM_WORDS(PW)) dut_u (
    .mclk_i, .sys_rst_i, .dsp_reset_bit_i, .x_address_bus_i, .x_rd_i,
    .x_wr_i, .x_wdata_i, .x_periph_rdata_i, .x_data_bus_o, .x_valid_o,
    .x_periph_sel_o, .y_address_bus_i, .y_rd_i, .y_wr_i, .y_wdata_i,
    .y_periph_rdata_i, .y_data_bus_o, .y_valid_o, .y_periph_sel_o,
    .program_address_bus_i, .fetch_i, .program_data_bus_o, .fetch_valid_o,
    .pmove_address_i, .pmove_rd_i, .pmove_wr_i, .pmove_wdata_i,
    .pmove_rdata_o, .pmove_valid_o, .mode_wr_i, .mode_wdata_i, .boot_mode_o
  );

  dms_core_model core_u (
    .mclk_i, .xa_o(x_address_bus_i), .xr_o(x_rd_i), .xw_o(x_wr_i),
    .xd_o(x_wdata_i), .xp_o(x_periph_rdata_i), .ya_o(y_address_bus_i),
    .yr_o(y_rd_i), .yw_o(y_wr_i), .yd_o(y_wdata_i),
    .yp_o(y_periph_rdata_i), .pa_o(program_address_bus_i), .pf_o(fetch_i),
    .ma_o(pmove_address_i), .mr_o(pmove_rd_i), .mw_o(pmove_wr_i),
    .md_o(pmove_wdata_i), .mw_mode_o(mode_wr_i), .md_mode_o(mode_wdata_i)
  );

  // 40 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // Word compare
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Flag compare
  task automatic chk1(input logic g, input logic e);
    chk({23'h0, g}, {23'h0, e});
  endtask

  // Data bus result on X or Y: valid, word, peripheral select
  task automatic chkd(input bit y, input logic v, input logic [23:0] d,
                      input logic s);
    chk1(y ? y_valid_o : x_valid_o, v);
    chk(y ? y_data_bus_o : x_data_bus_o, d);
    chk1(y ? y_periph_sel_o : x_periph_sel_o, s);
  endtask

  // RAM, ROM, peripheral and unmapped space on one data bus
  task automatic t_data(input bit y);
    logic [7:0]  k;
    logic [23:0] p;
    k = y ? dms_pkg::KIND_Y_ROM : dms_pkg::KIND_X_ROM;
    core_u.dreq(y, 1'b0, 1'b1, 16'h01ff, 24'ha5c3e1);
    core_u.tick();
    core_u.dreq(y, 1'b1, 1'b1, 16'h01ff, 24'h123456);
    core_u.tick();
    chkd(y, 1'b1, 24'ha5c3e1, 1'b0);
    core_u.dreq(y, 1'b1, 1'b1, 16'h0203, 24'hffffff);
    core_u.tick();
    chkd(y, 1'b1, {k, 8'h00, 8'h03}, 1'b0);
    core_u.dreq(y, 1'b1, 1'b0, 16'h01ff, 24'h0);
    core_u.tick();
    chkd(y, 1'b1, 24'h123456, 1'b0);
    core_u.dreq(y, 1'b1, 1'b0, 16'hffc0, 24'h0);
    p = y ? y_periph_rdata_i : x_periph_rdata_i;
    core_u.tick();
    chkd(y, 1'b1, p, 1'b1);
    core_u.dreq(y, 1'b1, 1'b0, 16'h0300, 24'h0);
    core_u.tick();
    chkd(y, 1'b1, 24'h0, 1'b0);
    core_u.dreq(y, 1'b1, 1'b0, 16'h02ff, 24'h0);
    core_u.tick();
    chkd(y, 1'b1, {k, 8'h00, 8'hff}, 1'b0);
    core_u.clear();
    core_u.tick();
    chkd(y, 1'b0, 24'h0, 1'b0);
  endtask

  // Boot mode: fetch from boot ROM while the loader fills program RAM
  task automatic t_boot();
    core_u.fetch(1'b1, 16'h0005);
    core_u.move(1'b0, 1'b1, 16'h0005, 24'h0badc0);
    core_u.tick();
    chk1(fetch_valid_o, 1'b1);
    chk(program_data_bus_o, {KB, 8'h00, 8'h05});
    core_u.fetch(1'b1, 16'h007f);
    core_u.move(1'b1, 1'b0, 16'h0005, 24'h0);
    core_u.tick();
    chk(program_data_bus_o, {KB, 8'h00, 8'h7f});
    chk1(pmove_valid_o, 1'b1);
    chk(pmove_rdata_o, 24'h0badc0);
    core_u.fetch(1'b1, 16'h0080);
    core_u.move(1'b0, 1'b1, 16'(PW - 1), 24'h777777);
    core_u.tick();
    chk(program_data_bus_o, 24'h0);
  endtask

  // Normal mode: fetch from program RAM, move has priority
  task automatic t_normal();
    core_u.fetch(1'b0, 16'h0);
    core_u.move(1'b0, 1'b0, 16'h0, 24'h0);
    core_u.mode(1'b1, 1'b0);
    core_u.tick();
    chk1(boot_mode_o, 1'b0);
    core_u.mode(1'b0, 1'b0);
    core_u.fetch(1'b1, 16'h0005);
    core_u.dreq(1'b0, 1'b0, 1'b1, 16'h0005, 24'h999999);
    core_u.tick();
    chk1(fetch_valid_o, 1'b1);
    chk(program_data_bus_o, 24'h0badc0);
    core_u.dreq(1'b0, 1'b0, 1'b0, 16'h0005, 24'h0);
    core_u.fetch(1'b1, 16'(PW - 1));
    core_u.tick();
    chk(program_data_bus_o, 24'h777777);
    core_u.fetch(1'b1, 16'(PW));
    core_u.tick();
    chk(program_data_bus_o, 24'h0);
    core_u.fetch(1'b1, 16'h0005);
    core_u.move(1'b1, 1'b0, 16'h0005, 24'h0);
    core_u.tick();
    chk1(fetch_valid_o, 1'b0);
    chk(pmove_rdata_o, 24'h0badc0);
    core_u.fetch(1'b0, 16'h0);
    core_u.move(1'b0, 1'b1, 16'h0006, 24'h3c3c3c);
    core_u.tick();
    core_u.move(1'b0, 1'b0, 16'h0, 24'h0);
    core_u.fetch(1'b1, 16'h0006);
    core_u.tick();
    chk(program_data_bus_o, 24'h3c3c3c);
  endtask

  // Core reset bit wins over a mode clear and keeps memory contents
  task automatic t_rst_bit();
    core_u.clear();
    dsp_reset_bit_i = 1'b1;
    core_u.mode(1'b1, 1'b0);
    core_u.tick();
    chk1(boot_mode_o, 1'b1);
    dsp_reset_bit_i = 1'b0;
    core_u.mode(1'b0, 1'b0);
    core_u.fetch(1'b1, 16'h0005);
    core_u.tick();
    chk(program_data_bus_o, {KB, 8'h00, 8'h05});
    core_u.fetch(1'b0, 16'h0);
    core_u.dreq(1'b0, 1'b1, 1'b0, 16'h0005, 24'h0);
    core_u.tick();
    chk(x_data_bus_o, 24'h999999);
  endtask

  // Verdict and end of run
  task automatic stop_test();
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence; reset held for 20 cycles
  initial begin
    sys_rst_i = 1'b1;
    dsp_reset_bit_i = 1'b0;
    repeat (20) @(posedge mclk_i);
    #1 sys_rst_i = 1'b0;
    chk1(boot_mode_o, dms_pkg::BOOT_MODE_RST);
    chk1(x_valid_o, 1'b0);
    t_data(1'b0);
    t_data(1'b1);
    t_boot();
    t_normal();
    t_rst_bit();
    stop_test();
  end

  // Watchdog, well beyond the roughly 50 cycles the tests need
  initial begin
    repeat (2000) @(posedge mclk_i);
    mismatches++;
    $display("mismatch at %0t: timeout", $time);
    stop_test();
  end
endmodule  // tb_top
